// ---- core/shared_pin_gpio_port.sv ----
// shared_pin_gpio_port: eight gpio pins sharing the analog input pins, with
// routing, direction and level registers behind a simple register port.
// assumes: synchronous active-low reset, read data one cycle after the read strobe,
// the pad ring resolves pin levels from pin_out and pin_oe.
//
// What this block does
// RULE1: routing register at 12h, reset 00h.
// RULE2: route bits 0-3 join analog pins 3-6.
// RULE3: route bits 4-7 join pins 7-9, common.
// RULE4: route bit zero leaves gpio detached.
// RULE5: direction register at 13h, reset 00h.
// RULE6: direction 0 output, 1 input.
// RULE7: level register at 14h, reset 00h.
// RULE8: output pins read back as zero.
// RULE9: input pin writes only store the value.
// RULE10: level 0 low, 1 high.
// RULE11: input pins undriven, read sampled level.
// RULE12: output pins drive last written level.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module shared_pin_gpio_port
  import gpio_port_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [DATA_WIDTH-1:0] reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [DATA_WIDTH-1:0] reg_rdata,
  input  wire logic [PIN_COUNT-1:0]  pin_in,
  output logic      [PIN_COUNT-1:0]  pin_out,
  output logic      [PIN_COUNT-1:0]  pin_oe,
  output logic      [PIN_COUNT-1:0]  analog_join
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [PIN_COUNT-1:0]  route_bits_r;
    logic [PIN_COUNT-1:0]  direction_bits_r;
    logic [PIN_COUNT-1:0]  level_bits_r;
    logic [DATA_WIDTH-1:0] rdata_r;
    logic [PIN_COUNT-1:0]  pin_out_r;
    logic [PIN_COUNT-1:0]  pin_oe_r;
    logic [PIN_COUNT-1:0]  analog_join_r;
  } port_state_t;

  port_state_t          state_r;
  port_state_t          state_nxt;
  logic [PIN_COUNT-1:0] pin_sampled;
  logic [PIN_COUNT-1:0] level_view;

  pin_sync u_pin_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_sampled)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin read view of the level register

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_view
      // output pins read zero; input pins show the sampled pad level
      assign level_view[gi] = (state_r.direction_bits_r[gi] == DIR_INPUT)
                              ? pin_sampled[gi]  // RULE11 RULE10
                              : 1'b0;            // RULE8
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt         = state_r;
    state_nxt.rdata_r = READ_DATA_RESET;

    if (reg_write) begin
      case (reg_addr)
        ROUTE_SELECT_ADDR: begin
          state_nxt.route_bits_r = reg_wdata;  // RULE1
        end
        DIRECTION_SELECT_ADDR: begin
          state_nxt.direction_bits_r = reg_wdata;  // RULE5
        end
        PIN_LEVEL_ADDR: begin
          // input pins keep the write in the register without reaching the pad
          state_nxt.level_bits_r = reg_wdata;  // RULE7 RULE9
        end
        default: begin
        end
      endcase
    end

    if (reg_read) begin
      case (reg_addr)
        ROUTE_SELECT_ADDR:     state_nxt.rdata_r = state_r.route_bits_r;
        DIRECTION_SELECT_ADDR: state_nxt.rdata_r = state_r.direction_bits_r;
        PIN_LEVEL_ADDR:        state_nxt.rdata_r = level_view;
        default:               state_nxt.rdata_r = UNMAPPED_READ_VALUE;
      endcase
    end

    // pad drive updates on the same clock edge as the registers it follows
    for (int i = 0; i < PIN_COUNT; i++) begin
      state_nxt.pin_oe_r[i]  = (state_nxt.direction_bits_r[i] == DIR_OUTPUT);  // RULE6 RULE11
      state_nxt.pin_out_r[i] = state_nxt.level_bits_r[i]
                               & (state_nxt.direction_bits_r[i] == DIR_OUTPUT);  // RULE12 RULE10
    end

    // bit n joins gpio n to its analog pin: 3,4,5,6,7,8,9 then common
    state_nxt.analog_join_r = state_nxt.route_bits_r;  // RULE2 RULE3 RULE4

    if (!rst_n) begin
      state_nxt.route_bits_r     = ROUTE_SELECT_RESET;
      state_nxt.direction_bits_r = DIRECTION_SELECT_RESET;
      state_nxt.level_bits_r     = PIN_LEVEL_RESET;
      state_nxt.rdata_r          = READ_DATA_RESET;
      // reset leaves all pins as outputs driving low, matching the register reset
      state_nxt.pin_oe_r         = {PIN_COUNT{1'b1}};
      state_nxt.pin_out_r        = '0;
      state_nxt.analog_join_r    = '0;
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata   = state_r.rdata_r;
  assign pin_out     = state_r.pin_out_r;
  assign pin_oe      = state_r.pin_oe_r;
  assign analog_join = state_r.analog_join_r;

endmodule // shared_pin_gpio_port

// ---- core/gpio_port_pkg.sv ----
// gpio_port_pkg: register map, reset values and widths of the shared-pin gpio port.
// assumes: one 250 MHz clock domain, byte-wide register port.
package gpio_port_pkg;

  localparam int unsigned  PIN_COUNT        = 8;
  localparam int unsigned  ADDR_WIDTH       = 8;
  localparam int unsigned  DATA_WIDTH       = 8;

  localparam logic [7:0]   ROUTE_SELECT_ADDR     = 8'h12;
  localparam logic [7:0]   DIRECTION_SELECT_ADDR = 8'h13;
  localparam logic [7:0]   PIN_LEVEL_ADDR        = 8'h14;

  localparam logic [7:0]   ROUTE_SELECT_RESET     = 8'h00;
  localparam logic [7:0]   DIRECTION_SELECT_RESET = 8'h00;
  localparam logic [7:0]   PIN_LEVEL_RESET        = 8'h00;
  localparam logic [7:0]   READ_DATA_RESET        = 8'h00;
  localparam logic [7:0]   UNMAPPED_READ_VALUE    = 8'h00;

  // direction encoding per pin
  localparam logic         DIR_OUTPUT = 1'b0;
  localparam logic         DIR_INPUT  = 1'b1;

  // flip-flops between a pad and any logic that reads its level
  localparam int unsigned  SYNC_STAGES = 2;

endpackage : gpio_port_pkg

// ---- core/pin_sync.sv ----
// pin_sync: two-flop synchroniser for a vector of pin levels.
// assumes: inputs are asynchronous to clock; output is only read after stage two.
`timescale 1ns/1ps
module pin_sync
  import gpio_port_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [PIN_COUNT-1:0] async_in,
  output logic      [PIN_COUNT-1:0] sync_out
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] stage1_r;
    logic [PIN_COUNT-1:0] stage2_r;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  always_comb begin
    state_nxt          = state_r;
    state_nxt.stage1_r = async_in;
    state_nxt.stage2_r = state_r.stage1_r;
    if (!rst_n) begin
      state_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end

  assign sync_out = state_r.stage2_r;

endmodule // pin_sync

// ---- testbench/gpio_port_chk.sv ----
// gpio_port_chk: port assertions for the shared-pin gpio port.
// assumes: one clock, synchronous active-low reset.
`timescale 1ns/1ps
module gpio_port_chk
  import gpio_port_pkg::*;
(
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] analog_join,
  input wire logic       clock,
  input wire logic       rst_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [7:0] a); reg_write && reg_addr == a; endsequence
  sequence s_rd(logic [7:0] a); reg_read && reg_addr == a; endsequence
  a_route_write: assert property (s_wr(8'h12) |=> analog_join == $past(reg_wdata))
    else $error("route write not applied");
  a_route_hold: assert property (!(reg_write && reg_addr == 8'h12) |=> $stable(analog_join))
    else $error("route changed without write");
  a_dir_write: assert property (s_wr(8'h13) |=> pin_oe == ~$past(reg_wdata))
    else $error("direction write not applied");
  a_in_undriven: assert property ((pin_out & ~pin_oe) == 8'h00)
    else $error("input pin driven");
  a_level_out: assert property (s_wr(8'h14) |=> pin_out == ($past(reg_wdata) & pin_oe))
    else $error("output level wrong");
  a_rd_outzero: assert property (s_rd(8'h14) |=> (reg_rdata & pin_oe) == 8'h00)
    else $error("output bit read nonzero");
  a_rd_route: assert property (s_rd(8'h12) |=> reg_rdata == analog_join)
    else $error("route readback wrong");
  a_rd_dir: assert property (s_rd(8'h13) |=> reg_rdata == ~pin_oe)
    else $error("direction readback wrong");
  a_rd_unmapped: assert property (reg_read && !(reg_addr inside {[8'h12:8'h14]})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
endmodule // gpio_port_chk
////////////////////////////////////////////////////////////////
bind shared_pin_gpio_port gpio_port_chk u_chk (.reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .pin_out, .pin_oe, .analog_join, .clock, .rst_n);

// ---- testbench/pad_model.sv ----
// pad_model: external circuitry on the shared analog pins.
// assumes: pad level resolved from the port's drive and enable.
`timescale 1ns/1ps
module pad_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pad
);
  // far side only shows through where the port has let go
  assign pad = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // pad_model

// ---- testbench/tb.sv ----
// tb: register-level tests of the shared-pin gpio port.
// assumes: 250 MHz clock, read data one cycle after the strobe.
`timescale 1ns/1ps
module tb
  import gpio_port_pkg::*;
;
  logic       clock = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ext_level = 8'hAA;
  logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, analog_join;
  int         error_cnt = 0, checks_done = 0;
  always #2 clock = ~clock;
  shared_pin_gpio_port dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .pin_in, .pin_out, .pin_oe, .analog_join);
  pad_model pads (.pin_out, .pin_oe, .ext_level, .pad(pin_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk(pin_oe, 8'hFF);
    rdchk(ROUTE_SELECT_ADDR, 8'h00);
    rdchk(DIRECTION_SELECT_ADDR, 8'h00);
    rdchk(PIN_LEVEL_ADDR, 8'h00);
    chk(analog_join, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ROUTE_SELECT_ADDR, 8'h01 << i);
      chk(analog_join, 8'h01 << i);
      rdchk(ROUTE_SELECT_ADDR, 8'h01 << i);
    end
    wr(DIRECTION_SELECT_ADDR, 8'h0F);
    wr(PIN_LEVEL_ADDR, 8'hFF);
    chk(pin_oe, 8'hF0);
    chk(pin_out, 8'hF0);
    rdchk(DIRECTION_SELECT_ADDR, 8'h0F);
    rdchk(PIN_LEVEL_ADDR, 8'h0A);
    @(posedge clock);
    ext_level <= 8'h55;
    // two synchroniser stages plus margin
    repeat (3) @(posedge clock);
    rdchk(PIN_LEVEL_ADDR, 8'h05);
    wr(8'h15, 8'hFF);
    rdchk(8'h15, 8'h00);
    chk(analog_join, 8'h80);
    wr(DIRECTION_SELECT_ADDR, 8'h00);
    chk(pin_out, 8'hFF);
    wr(PIN_LEVEL_ADDR, 8'h3C);
    chk(pin_out, 8'h3C);
    rdchk(PIN_LEVEL_ADDR, 8'h00);
    test_done();
  end
  // tests take about 75 cycles; 5000 cycles means a hang
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
endmodule // tb
